// file: bench/psc_cfg_monitor.sv
// Purpose: Port checks for the shed config bank
// Assumes: One clock, synchronous reset
// Notes:   Accesses in the first edge after reset are ignored
`timescale 1ns/1ps
module psc_cfg_monitor
    import psc_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Word port
    input wire logic [7:0]  page,
    input wire logic [7:0]  cmd_code,
    input wire logic        wr_word,
    input wire logic        rd_word,
    input wire logic        rd_valid,
    input wire logic        cmd_refused,
    input wire logic [15:0] rd_data,
    // Decisions
    input wire logic [2:0]  active_phases_a,
    input wire logic        phase_add_a,
    input wire logic        phase_drop_a,
    input wire logic        discontinuous_conduction_a
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic dfh = cmd_code == CMD_PHASE_SHED_CONFIG;
    a_read_answer: assert property (dfh && rd_word && !wr_word &&
        page <= PAGE_CHAN_B && !$past(rst) |=> rd_valid && !cmd_refused)
        else $error("read not answered");
    a_bad_page: assert property (dfh && (wr_word || rd_word) &&
        page > PAGE_CHAN_B && !$past(rst) |=> cmd_refused && !rd_valid)
        else $error("bad page not refused");
    a_other_cmd: assert property (!dfh && (wr_word || rd_word)
        |=> !rd_valid && !cmd_refused) else $error("foreign command seen");
    a_data_hold: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved");
    a_b_masked: assert property (
        rd_valid && $past(page) == PAGE_CHAN_B
        |-> (rd_data & MASK_CHAN_A_ONLY) == 16'h0000)
        else $error("channel B shows A-only bits");
    a_dcond_one: assert property (discontinuous_conduction_a
        |-> $past(active_phases_a) == 3'h1)
        else $error("discontinuous mode off one phase");
    a_drop_two: assert property (phase_drop_a
        |-> $past(active_phases_a) == 3'h2) else $error("drop off two");
    a_add_max: assert property (phase_add_a
        |-> $past(active_phases_a) < PHASES_MAX_CHAN_A)
        else $error("add at full count");
endmodule
bind psc_phase_shed_config psc_cfg_monitor u_psc_cfg_monitor (
    .clk_sys(clk_sys), .rst(rst), .page(page), .cmd_code(cmd_code),
    .wr_word(wr_word), .rd_word(rd_word), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_refused(cmd_refused),
    .active_phases_a(active_phases_a), .phase_add_a(phase_add_a),
    .phase_drop_a(phase_drop_a),
    .discontinuous_conduction_a(discontinuous_conduction_a));

// file: bench/psc_host_model.sv
// Purpose: Management host issuing whole word transfers
// Assumes: Strobes launched just after a rising edge
// Notes:   Released write data is inverted so stale values never pass
`timescale 1ns/1ps
module psc_host_model
    import psc_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Requests
    output logic      [7:0]  page     = PAGE_CHAN_A,
    output logic      [7:0]  cmd_code = 8'h00,
    output logic             wr_word  = 1'b0,
    output logic             rd_word  = 1'b0,
    output logic      [15:0] wr_data  = 16'h0000,
    // Answers
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    input  wire logic        cmd_refused
);
    // One strobe cycle, answer taken 1 ns after the taking edge
    task automatic xfer(input logic [7:0] pg, cm, input logic wr,
        input logic [15:0] d, output logic [15:0] q, output logic [1:0] a);
        @(posedge clk_sys);
        page     <= pg;
        cmd_code <= cm;
        wr_word  <= wr;
        rd_word  <= !wr;
        wr_data  <= d;
        @(posedge clk_sys);
        wr_word  <= 1'b0;
        rd_word  <= 1'b0;
        wr_data  <= ~d;
        #1;
        q = rd_data;
        a = {rd_valid, cmd_refused};
    endtask
endmodule

// file: bench/psc_phase_shed_config_tb.sv
// Purpose: Self-checking bench for the shed config bank
// Assumes: Host model drives the word port, telemetry driven here
// Notes:   Telemetry is set one edge ahead of each decision check
`timescale 1ns/1ps
module psc_phase_shed_config_tb
    import psc_pkg::*;
;
    logic            clk_sys = 1'b0, rst = 1'b1;
    logic [15:0]     nvm_cfg_a = 16'hB6D5, nvm_cfg_b = 16'hFFFF;
    logic [7:0]      avg_a = '0, pk_a = '0, avg_b = '0, pk_b = '0;
    logic [2:0]      n_a = '0, n_b = '0;
    wire logic [15:0] wr_data, rd_data;
    wire logic [7:0] page, cmd_code;
    wire logic       wr_word, rd_word, rd_valid, cmd_refused;
    wire logic [5:0] dec_q;
    int              mismatches = 0, samples_checked = 0, cycles = 0;
    psc_phase_shed_config u_psc_phase_shed_config (
        .clk_sys(clk_sys), .rst(rst), .nvm_cfg_a(nvm_cfg_a),
        .nvm_cfg_b(nvm_cfg_b), .page(page), .cmd_code(cmd_code),
        .wr_word(wr_word), .rd_word(rd_word), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .cmd_refused(cmd_refused),
        .avg_current_a(avg_a), .peak_current_a(pk_a), .avg_current_b(avg_b),
        .peak_current_b(pk_b), .active_phases_a(n_a), .active_phases_b(n_b),
        .phase_add_a(dec_q[5]), .phase_drop_a(dec_q[4]),
        .discontinuous_conduction_a(dec_q[3]), .phase_add_b(dec_q[2]),
        .phase_drop_b(dec_q[1]), .discontinuous_conduction_b(dec_q[0]));
    psc_host_model u_psc_host_model (.clk_sys(clk_sys), .page(page),
        .cmd_code(cmd_code), .wr_word(wr_word), .rd_word(rd_word),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd_refused(cmd_refused));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            conclude();
        end
    end
    // For reads d is the expected word
    task automatic acc(input logic [7:0] pg, input logic wr,
                       input logic [15:0] d);
        logic [15:0] q;
        logic [1:0]  a;
        u_psc_host_model.xfer(pg, CMD_PHASE_SHED_CONFIG, wr, d, q, a);
        check(16'(a), wr ? 16'h0000 : 16'h0002);
        if (!wr)
            check(q, d);
    endtask
    task automatic dec(input logic [2:0] na, input logic [7:0] aa, pa,
                       input logic [2:0] nb, input logic [7:0] ab, pb,
                       input logic [5:0] e);
        @(posedge clk_sys);
        n_a   <= na;
        avg_a <= aa;
        pk_a  <= pa;
        n_b   <= nb;
        avg_b <= ab;
        pk_b  <= pb;
        @(posedge clk_sys);
        #1;
        check(16'(dec_q), 16'(e));
    endtask
    task automatic t_regs();
        logic [15:0] q;
        logic [1:0]  a;
        acc(PAGE_CHAN_A, 1'b0, 16'hB6D5);
        acc(PAGE_CHAN_B, 1'b0, 16'hE07F);
        acc(PAGE_CHAN_A, 1'b1, 16'h1234);
        acc(PAGE_CHAN_B, 1'b1, 16'hFFFF);
        acc(PAGE_CHAN_A, 1'b0, 16'h1234);
        acc(PAGE_CHAN_B, 1'b0, 16'hE07F);
        u_psc_host_model.xfer(8'h02, CMD_PHASE_SHED_CONFIG, 1'b0, '0, q, a);
        check(16'(a), 16'h0001);
        u_psc_host_model.xfer(PAGE_CHAN_A, 8'hDE, 1'b1, 16'hFFFF, q, a);
        check(16'(a), 16'h0000);
        acc(PAGE_CHAN_A, 1'b0, 16'h1234);
    endtask
    task automatic t_thresh();
        logic [7:0] th, dt;
        logic [5:0] e;
        for (int k = 0; k < 16; k++) begin
            acc(PAGE_CHAN_A, 1'b1,
                {1'b1, {6{2'(k % 4)}}, 1'b1, 2'(k / 4)});
            dt = 8'(10 + 2 * (k / 4) + 2 * (k % 4));
            for (int n = 1; n < 6; n++) begin
                th = 8'(n*(12+2*(k/4))+6+2*(k%4));
                e = {1'b0, n == 2, n == 1, 3'b000};
                dec(3'(n), dt, th - 8'h01, '0, '0, '0, e);
                e = {1'b1, 1'b0, n == 1, 3'b000};
                dec(3'(n), dt + 8'h01, th, '0, '0, '0, e);
            end
        end
        dec(3'h6, 8'h00, 8'hFF, '0, '0, '0, 6'h00);
        acc(PAGE_CHAN_A, 1'b1, 16'h7FFB);
        dec(3'h2, 8'h00, 8'h00, '0, '0, '0, 6'h00);
        dec(3'h1, 8'h00, 8'h00, '0, '0, '0, 6'h00);
    endtask
    task automatic t_chan_b();
        acc(PAGE_CHAN_B, 1'b1, 16'h0004);
        dec(3'h1, '0, '0, 3'h2, 8'h0A, 8'h1E, 6'h06);
        dec(3'h1, '0, '0, 3'h3, 8'h00, 8'hFF, 6'h00);
        // Channel B light-load mode must rise on its own page setting
        acc(PAGE_CHAN_B, 1'b1, 16'h8004);
        acc(PAGE_CHAN_B, 1'b0, 16'h8004);
        dec(3'h1, '0, '0, 3'h1, 8'h00, 8'h00, 6'h01);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_thresh();
        t_chan_b();
        conclude();
    end
endmodule

// file: common/psc_pkg.sv
// Purpose: Constants for the phase shedding configuration register bank
// Assumes: Register reached by command code over a management word port
// Notes:   Currents are in amperes, unsigned 8-bit
package psc_pkg;
    // ************************************************************
    // Command and page
    // ************************************************************
    localparam logic [7:0]  CMD_PHASE_SHED_CONFIG = 8'hDF;
    localparam logic [7:0]  PAGE_CHAN_A           = 8'h00;
    localparam logic [7:0]  PAGE_CHAN_B           = 8'h01;
    localparam int          NUM_CHAN              = 2;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          POS_LIGHT_LOAD_EN     = 15;
    localparam int          POS_DROP_2TO1         = 13;
    localparam int          POS_ADD_5TO6          = 11;
    localparam int          POS_ADD_4TO5          = 9;
    localparam int          POS_ADD_3TO4          = 7;
    localparam int          POS_ADD_2TO3          = 5;
    localparam int          POS_ADD_1TO2          = 3;
    localparam int          POS_ALLOW_SINGLE      = 2;
    localparam int          POS_PEAK_EFF_SEL      = 0;
    // Bits that exist only on channel A
    localparam logic [15:0] MASK_CHAN_A_ONLY      = 16'h1F80;
    // ************************************************************
    // Threshold arithmetic (amperes)
    // ************************************************************
    localparam logic [7:0]  PEAK_EFF_BASE_A       = 8'h0C;
    localparam logic [7:0]  PEAK_EFF_STEP_A       = 8'h02;
    localparam logic [7:0]  ADD_OFFSET_BASE_A     = 8'h06;
    localparam logic [7:0]  FINE_STEP_A           = 8'h02;
    localparam logic [7:0]  DROP_OFFSET_NEG_A     = 8'h02;
    localparam logic [7:0]  PHASE_COUNT_MAX       = 8'h06;
    localparam logic [7:0]  PHASE_COUNT_MIN_DYN   = 8'h02;
    localparam logic [2:0]  PHASES_MAX_CHAN_B     = 3'h3;
    localparam logic [2:0]  PHASES_MAX_CHAN_A     = 3'h6;
    typedef enum logic [1:0] {
        PSC_ACC_IDLE,
        PSC_ACC_WRITE,
        PSC_ACC_READ
    } psc_acc_type;
endpackage

// file: rtl/psc_phase_shed_config.sv
// Purpose: Paged phase shedding configuration register and decisions
// Assumes: Word transactions decoded upstream into command/data strobes
// Notes:   Defaults come from the nonvolatile image on the first edge after reset release
//
// What this block does
// RULE_01: Register reached by command DFh words
// RULE_02: One copy per channel, page selects
// RULE_03: Bit 15 enables discontinuous conduction on one phase
// RULE_04: Bits 14:13 trim two-to-one drop
// RULE_05: Drop compares averaged per-phase current
// RULE_06: Add compares peak per-phase current
// RULE_07: Bits 12:11 trim five-to-six add
// RULE_08: Bits 10:9 trim four-to-five add
// RULE_09: All fields RW, reset from NVM
// RULE_10: Coarse field selects 12..18 A point
// RULE_11: Enable bit permits two-to-one shedding
// RULE_12: Bits 8:7 trim three-to-four add
// RULE_13: One-to-two add is 1x plus 6..12
// RULE_14: Two-to-three add is 2x plus 6..12
// RULE_15: Channel A only fields read zero on B
`timescale 1ns/1ps
module psc_phase_shed_config
    import psc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Nonvolatile defaults, one word per channel
    input  wire logic [15:0] nvm_cfg_a,
    input  wire logic [15:0] nvm_cfg_b,
    // Management word port
    input  wire logic [7:0]  page,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        wr_word,
    input  wire logic        rd_word,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             cmd_refused,
    // Current telemetry, per-phase amperes, per channel
    input  wire logic [7:0]  avg_current_a,
    input  wire logic [7:0]  peak_current_a,
    input  wire logic [7:0]  avg_current_b,
    input  wire logic [7:0]  peak_current_b,
    input  wire logic [2:0]  active_phases_a,
    input  wire logic [2:0]  active_phases_b,
    // Shedding requests and mode
    output logic             phase_add_a,
    output logic             phase_drop_a,
    output logic             phase_add_b,
    output logic             phase_drop_b,
    output logic             discontinuous_conduction_a,
    output logic             discontinuous_conduction_b
);
    // ************************************************************
    // Register storage
    // ************************************************************
    logic [15:0] cfg_q [NUM_CHAN];
    logic [15:0] cfg_d [NUM_CHAN];
    logic        loaded_q;
    logic        loaded_d;
    logic [15:0] rd_data_q, rd_data_d;
    logic        rd_valid_q, rd_valid_d;
    logic        refused_q, refused_d;
    logic        hit;
    logic        page_ok;
    logic        chan;

    assign hit     = (cmd_code == CMD_PHASE_SHED_CONFIG); // RULE_01
    assign page_ok = (page == PAGE_CHAN_A) || (page == PAGE_CHAN_B); // RULE_02
    assign chan    = (page == PAGE_CHAN_B);

    always_comb begin
        loaded_d   = 1'b1;
        cfg_d      = cfg_q;
        rd_data_d  = rd_data_q;
        rd_valid_d = 1'b0;
        refused_d  = 1'b0;
        if (!loaded_q) begin
            // Strap-like NVM words are sampled after reset release
            cfg_d[0] = nvm_cfg_a; // RULE_09
            cfg_d[1] = nvm_cfg_b & ~MASK_CHAN_A_ONLY; // RULE_15
        end else if (hit && (wr_word || rd_word)) begin
            if (!page_ok) begin
                refused_d = 1'b1;
            end else if (wr_word) begin
                cfg_d[chan] = chan ? (wr_data & ~MASK_CHAN_A_ONLY)
                                   : wr_data; // RULE_09 RULE_15
            end else begin
                rd_data_d  = cfg_q[chan];
                rd_valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_q[0]   <= 16'h0000;
            cfg_q[1]   <= 16'h0000;
            loaded_q   <= 1'b0;
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
            refused_q  <= 1'b0;
        end else begin
            cfg_q      <= cfg_d;
            loaded_q   <= loaded_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            refused_q  <= refused_d;
        end
    end

    assign rd_data     = rd_data_q;
    assign rd_valid    = rd_valid_q;
    assign cmd_refused = refused_q;

    // ************************************************************
    // Per-channel shedding decisions
    // ************************************************************
    logic [7:0] avg_cur  [NUM_CHAN];
    logic [7:0] peak_cur [NUM_CHAN];
    logic [2:0] phases   [NUM_CHAN];
    logic [2:0] max_ph   [NUM_CHAN];
    logic       add_d    [NUM_CHAN];
    logic       drop_d   [NUM_CHAN];
    logic       dcond_d  [NUM_CHAN];
    logic       add_q    [NUM_CHAN];
    logic       drop_q   [NUM_CHAN];
    logic       dcond_q  [NUM_CHAN];

    assign avg_cur[0]  = avg_current_a;
    assign avg_cur[1]  = avg_current_b;
    assign peak_cur[0] = peak_current_a;
    assign peak_cur[1] = peak_current_b;
    assign phases[0]   = active_phases_a;
    assign phases[1]   = active_phases_b;
    assign max_ph[0]   = PHASES_MAX_CHAN_A;
    assign max_ph[1]   = PHASES_MAX_CHAN_B;

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c = c + 1) begin : g_chan
            logic [7:0] drop21;
            logic [7:0] add_thr [1:5];
            logic [7:0] add_sel;
            logic       one_phase;

            psc_threshold_calc u_calc (
                .cfg                 (cfg_q[c]),
                .peak_eff_current    (),
                .drop_two_to_one_thr (drop21),
                .add_thr             (add_thr)
            );

            assign one_phase = (phases[c] == 3'h1);

            always_comb begin
                add_sel = 8'hFF;
                if (phases[c] >= 3'h1 && phases[c] <= 3'h5) begin
                    add_sel = add_thr[phases[c]];
                end
                // Peak current decides phase adding
                add_d[c] = (phases[c] < max_ph[c])
                        && (peak_cur[c] >= add_sel); // RULE_06
                // Averaged current decides the two-to-one drop;
                // stop at two phases unless single phase is allowed
                drop_d[c] = (phases[c] == 3'h2)
                         && cfg_q[c][POS_ALLOW_SINGLE] // RULE_11
                         && (avg_cur[c] <= drop21); // RULE_05
                dcond_d[c] = one_phase
                          && cfg_q[c][POS_LIGHT_LOAD_EN]; // RULE_03
            end

            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    add_q[c]  <= 1'b0;
                    drop_q[c] <= 1'b0;
                    dcond_q[c] <= 1'b0;
                end else begin
                    add_q[c]  <= add_d[c];
                    drop_q[c] <= drop_d[c];
                    dcond_q[c] <= dcond_d[c];
                end
            end
        end
    endgenerate

    assign phase_add_a                = add_q[0];
    assign phase_drop_a               = drop_q[0];
    assign phase_add_b                = add_q[1];
    assign phase_drop_b               = drop_q[1];
    assign discontinuous_conduction_a = dcond_q[0];
    assign discontinuous_conduction_b = dcond_q[1];
endmodule

// file: rtl/psc_threshold_calc.sv
// Purpose: Builds the add and drop thresholds for one channel
// Assumes: Config word already masked for the channel
// Notes:   Purely combinational, registered by the caller
`timescale 1ns/1ps
module psc_threshold_calc
    import psc_pkg::*;
(
    // Configuration
    input  wire logic [15:0] cfg,
    // Thresholds in amperes
    output logic      [7:0]  peak_eff_current,
    output logic      [7:0]  drop_two_to_one_thr,
    output logic      [7:0]  add_thr [1:5]
);
    logic [7:0] iep;
    logic [1:0] code [1:5];

    assign code[1] = cfg[POS_ADD_1TO2 +: 2];
    assign code[2] = cfg[POS_ADD_2TO3 +: 2];
    assign code[3] = cfg[POS_ADD_3TO4 +: 2];
    assign code[4] = cfg[POS_ADD_4TO5 +: 2];
    assign code[5] = cfg[POS_ADD_5TO6 +: 2];

    always_comb begin
        iep = PEAK_EFF_BASE_A
            + PEAK_EFF_STEP_A * {6'h00, cfg[POS_PEAK_EFF_SEL +: 2]}; // RULE_10
        peak_eff_current    = iep;
        // Code 00b sits 2 A below one times the peak point
        drop_two_to_one_thr = iep - DROP_OFFSET_NEG_A
            + FINE_STEP_A * {6'h00, cfg[POS_DROP_2TO1 +: 2]}; // RULE_04
    end

    genvar n;
    generate
        for (n = 1; n <= 5; n = n + 1) begin : g_add
            // n times the peak point plus 6..12 A
            assign add_thr[n] = iep * 8'(n) // RULE_13 RULE_14
                + ADD_OFFSET_BASE_A // RULE_12 RULE_08
                + FINE_STEP_A * {6'h00, code[n]}; // RULE_07
        end
    endgenerate
endmodule
